// ===== pss_pkg.sv
/*
  Shared constants and carriers for the port split link recovery block.
  Assumes a 20 MHz hub clock and the hub's internal configuration access port.
*/
package pss_pkg;

  // --------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------
  localparam logic [15:0] SPLIT_ENABLE_PER_PORT_ADDR = 16'h3c48;
  localparam logic [15:0] SPLIT_ENABLE_GLOBAL_ADDR = 16'h4141;
  localparam logic [15:0] PORT3_SPLIT_PIN_SELECT_ADDR = 16'h416e;
  localparam logic [15:0] PORT4_SPLIT_PIN_SELECT_ADDR = 16'h416f;
  localparam logic [15:0] LINK_STUCK_TIMEOUT_ADDR = 16'h4171;
  localparam logic [15:0] POWER_OFF_PULSE_LENGTH_ADDR = 16'h4176;
  localparam logic [15:0] SPLIT_STATUS_ADDR = 16'h4177;

  // --------------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------------
  localparam int PORT3_EN_BIT = 5;
  localparam int PORT4_EN_BIT = 6;
  localparam int GLOBAL_EN_BIT = 0;
  localparam logic [7:0] SPLIT_ENABLE_PER_PORT_RST = 8'h00;
  localparam logic [7:0] SPLIT_ENABLE_PER_PORT_MASK = 8'hfe;
  localparam logic [7:0] SPLIT_ENABLE_GLOBAL_RST = 8'h00;
  localparam logic [7:0] SPLIT_ENABLE_GLOBAL_MASK = 8'h01;
  localparam logic [7:0] PIN_SELECT_RST = 8'h00;
  localparam logic [7:0] LINK_STUCK_TIMEOUT_RST = 8'h05;
  localparam logic [7:0] LINK_STUCK_TIMEOUT_MASK = 8'h07;
  localparam logic [7:0] POWER_OFF_PULSE_LENGTH_RST = 8'h05;

  // --------------------------------------------------------------------
  // Pin select codes
  // --------------------------------------------------------------------
  localparam logic [7:0] P3_SEL_PIN_66 = 8'h42;
  localparam logic [7:0] P3_SEL_PIN_5 = 8'h05;
  localparam logic [7:0] P4_SEL_PIN_6 = 8'h06;
  localparam logic [7:0] P4_SEL_PIN_4 = 8'h04;

  // --------------------------------------------------------------------
  // Link training states that count as stuck
  // --------------------------------------------------------------------
  localparam logic [3:0] LTS_STUCK_LO = 4'h4;
  localparam logic [3:0] LTS_STUCK_HI = 4'h9;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam logic [11:0] TMO_100_MS = 12'h064;
  localparam logic [11:0] TMO_250_MS = 12'h0fa;
  localparam logic [11:0] TMO_750_MS = 12'h2ee;
  localparam logic [11:0] TMO_1000_MS = 12'h3e8;
  localparam logic [11:0] TMO_2000_MS = 12'h7d0;
  localparam logic [11:0] PULSE_MIN_MS = 12'h15e;
  localparam logic [11:0] PULSE_STEP_MS = 12'h00a;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic o;
    logic oe;
  } pss_pin_s;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } pss_cfg_req_s;

endpackage

// ===== pss_link_wdog.sv
/*
  Per-port link watchdog: times a stuck link training state and produces the
  low power pulse on the split power pin.
  Assumes a one-cycle millisecond tick enable from the parent.
*/
`timescale 1ns/1ps
module pss_link_wdog (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_enable,
  input wire logic i_ms_tick,
  input wire logic [11:0] i_timeout_ms,
  input wire logic [11:0] i_pulse_ms,
  input wire logic [3:0] i_link_state,
  // Result
  output logic o_power_on,
  output logic o_toggling
);

  typedef enum logic [1:0] {
    PSS_MONITOR = 2'b01,
    PSS_POWER_OFF = 2'b10
  } pss_wdog_e;

  pss_wdog_e state_q;
  pss_wdog_e state_d;
  logic [11:0] ms_q;
  logic [11:0] ms_d;
  logic [3:0] last_state_q;

  // --------------------------------------------------------------------
  // Stuck detection
  // --------------------------------------------------------------------
  wire logic in_stuck_set = (i_link_state >= pss_pkg::LTS_STUCK_LO) &&
                            (i_link_state <= pss_pkg::LTS_STUCK_HI);
  wire logic same_state = (i_link_state == last_state_q);
  wire logic armed = i_enable && (i_timeout_ms != 12'h000);
  wire logic expired = i_ms_tick && (ms_q + 12'h001 >= i_timeout_ms);
  wire logic pulse_done = i_ms_tick && (ms_q + 12'h001 >= i_pulse_ms);

  always_comb begin
    state_d = state_q;
    ms_d = ms_q;
    case (state_q)
      PSS_MONITOR: begin
        // Any state change or a healthy state means the link is alive
        if (!armed || !in_stuck_set || !same_state) begin
          ms_d = 12'h000;
        end else if (expired) begin
          ms_d = 12'h000;
          state_d = PSS_POWER_OFF;
        end else if (i_ms_tick) begin
          ms_d = ms_q + 12'h001;
        end
      end
      PSS_POWER_OFF: begin
        if (pulse_done) begin
          ms_d = 12'h000;
          state_d = PSS_MONITOR;
        end else if (i_ms_tick) begin
          ms_d = ms_q + 12'h001;
        end
      end
      default: begin
        state_d = PSS_MONITOR;
        ms_d = 12'h000;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= PSS_MONITOR;
      ms_q <= 12'h000;
      last_state_q <= 4'h0;
    end else begin
      state_q <= state_d;
      ms_q <= ms_d;
      last_state_q <= i_link_state;
    end
  end

  // Pulse runs to completion even if split is disabled meanwhile
  assign o_power_on = (state_q != PSS_POWER_OFF);
  assign o_toggling = (state_q == PSS_POWER_OFF);

endmodule

// ===== pss_port_split.sv
/*
  Port split control for downstream ports 3 and 4: configuration registers,
  split power pin routing and link stuck recovery.
  Assumes the hub's configuration access port (SMBus stage or OTP loader) on
  the same clock, and link training states from the port logic.
*/
`timescale 1ns/1ps
module pss_port_split #(
  parameter int TICK_CYC = pss_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET_N,
  // Configuration access
  input wire pss_pkg::pss_cfg_req_s I_CFG_REQ,
  output logic [7:0] O_CFG_RDATA,
  output logic O_CFG_RVALID,
  // OTP override of the link timeout
  input wire logic I_OTP_TIMEOUT_LOAD,
  input wire logic [2:0] I_OTP_TIMEOUT,
  // Link training state status per port
  input wire logic [3:0] I_PORT3_LINK_STATE,
  input wire logic [3:0] I_PORT4_LINK_STATE,
  // Ordinary port power control, passed through
  input wire logic [1:0] I_PORT_POWER_CONTROL,
  output logic [1:0] O_PORT_POWER_CONTROL_PIN,
  // Split power pins
  output pss_pkg::pss_pin_s O_GENERAL_PIN_66,
  output pss_pkg::pss_pin_s O_GENERAL_PIN_5,
  output pss_pkg::pss_pin_s O_GENERAL_PIN_6,
  output pss_pkg::pss_pin_s O_GENERAL_PIN_4
);

  // --------------------------------------------------------------------
  // Decoders
  // --------------------------------------------------------------------
  function automatic logic [11:0] timeout_ms(input logic [2:0] code);
    case (code)
      3'h1: timeout_ms = pss_pkg::TMO_100_MS;
      3'h2: timeout_ms = pss_pkg::TMO_250_MS;
      3'h3: timeout_ms = pss_pkg::TMO_750_MS;
      3'h4: timeout_ms = pss_pkg::TMO_1000_MS;
      3'h5: timeout_ms = pss_pkg::TMO_1000_MS;
      3'h6: timeout_ms = pss_pkg::TMO_2000_MS;
      default: timeout_ms = 12'h000;
    endcase
  endfunction

  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [7:0] per_port_q;
  logic [7:0] global_q;
  logic [7:0] p3_sel_q;
  logic [7:0] p4_sel_q;
  logic [7:0] timeout_q;
  logic [7:0] pulse_len_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [14:0] tick_cnt_q;
  logic ms_tick_q;
  logic [1:0] power_on;
  logic [1:0] toggling;

  wire logic wr = I_CFG_REQ.wr;
  wire logic [15:0] addr = I_CFG_REQ.addr;
  wire logic [7:0] wdata = I_CFG_REQ.wdata;
  wire logic rd = I_CFG_REQ.rd;

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      per_port_q <= pss_pkg::SPLIT_ENABLE_PER_PORT_RST;
      global_q <= pss_pkg::SPLIT_ENABLE_GLOBAL_RST;
      p3_sel_q <= pss_pkg::PIN_SELECT_RST;
      p4_sel_q <= pss_pkg::PIN_SELECT_RST;
      timeout_q <= pss_pkg::LINK_STUCK_TIMEOUT_RST;
      pulse_len_q <= pss_pkg::POWER_OFF_PULSE_LENGTH_RST;
    end else begin
      // Reserved bits are dropped on write so they always read back as zero
      if (wr && hit(addr, pss_pkg::SPLIT_ENABLE_PER_PORT_ADDR)) begin
        per_port_q <= wdata & pss_pkg::SPLIT_ENABLE_PER_PORT_MASK;
      end
      if (wr && hit(addr, pss_pkg::SPLIT_ENABLE_GLOBAL_ADDR)) begin
        global_q <= wdata & pss_pkg::SPLIT_ENABLE_GLOBAL_MASK;
      end
      if (wr && hit(addr, pss_pkg::PORT3_SPLIT_PIN_SELECT_ADDR)) begin
        p3_sel_q <= wdata;
      end
      if (wr && hit(addr, pss_pkg::PORT4_SPLIT_PIN_SELECT_ADDR)) begin
        p4_sel_q <= wdata;
      end
      // OTP override wins over a simultaneous register write
      if (I_OTP_TIMEOUT_LOAD) begin
        timeout_q <= {5'h00, I_OTP_TIMEOUT};
      end else if (wr && hit(addr, pss_pkg::LINK_STUCK_TIMEOUT_ADDR)) begin
        timeout_q <= wdata & pss_pkg::LINK_STUCK_TIMEOUT_MASK;
      end
      if (wr && hit(addr, pss_pkg::POWER_OFF_PULSE_LENGTH_ADDR)) begin
        pulse_len_q <= wdata;
      end
    end
  end

  // --------------------------------------------------------------------
  // Status
  // --------------------------------------------------------------------
  // Lets software see a recovery in progress without watching the pin
  wire logic [1:0] pin_low = ~power_on;
  wire logic [7:0] status = {4'h0, toggling, pin_low};

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  wire logic [7:0] rd_mux =
    hit(addr, pss_pkg::SPLIT_ENABLE_PER_PORT_ADDR) ? per_port_q :
    hit(addr, pss_pkg::SPLIT_ENABLE_GLOBAL_ADDR) ? global_q :
    hit(addr, pss_pkg::PORT3_SPLIT_PIN_SELECT_ADDR) ? p3_sel_q :
    hit(addr, pss_pkg::PORT4_SPLIT_PIN_SELECT_ADDR) ? p4_sel_q :
    hit(addr, pss_pkg::LINK_STUCK_TIMEOUT_ADDR) ? timeout_q :
    hit(addr, pss_pkg::POWER_OFF_PULSE_LENGTH_ADDR) ? pulse_len_q :
    hit(addr, pss_pkg::SPLIT_STATUS_ADDR) ? status : 8'h00;

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd;
      if (rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign O_CFG_RDATA = rdata_q;
  assign O_CFG_RVALID = rvalid_q;

  // --------------------------------------------------------------------
  // Millisecond tick
  // --------------------------------------------------------------------
  // Long timeouts count milliseconds, keeping the per-port counters narrow
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tick_cnt_q <= 15'h0000;
      ms_tick_q <= 1'b0;
    end else if (tick_cnt_q == 15'(TICK_CYC - 1)) begin
      tick_cnt_q <= 15'h0000;
      ms_tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 15'h0001;
      ms_tick_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Per-port split control
  // --------------------------------------------------------------------
  // Timeouts count whole ticks, so expiry may come up to one tick early
  wire logic [11:0] tmo_ms = timeout_ms(timeout_q[2:0]);
  wire logic [11:0] pulse_ms = pss_pkg::PULSE_MIN_MS +
                               12'(pulse_len_q) * pss_pkg::PULSE_STEP_MS;
  wire logic global_en = global_q[pss_pkg::GLOBAL_EN_BIT];
  wire logic [1:0] split_en = {per_port_q[pss_pkg::PORT4_EN_BIT] & global_en,
                               per_port_q[pss_pkg::PORT3_EN_BIT] & global_en};
  wire logic [3:0] link_state [2];
  assign link_state[0] = I_PORT3_LINK_STATE;
  assign link_state[1] = I_PORT4_LINK_STATE;

  generate
    for (genvar p = 0; p < 2; p++) begin : g_port
      pss_link_wdog u_wdog (
        .i_clk(I_MCLK),
        .i_rst_n(I_RESET_N),
        .i_enable(split_en[p]),
        .i_ms_tick(ms_tick_q),
        .i_timeout_ms(tmo_ms),
        .i_pulse_ms(pulse_ms),
        .i_link_state(link_state[p]),
        .o_power_on(power_on[p]),
        .o_toggling(toggling[p])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // Pins
  // --------------------------------------------------------------------
  // Ordinary path keeps its own overcurrent handling elsewhere
  assign O_PORT_POWER_CONTROL_PIN = I_PORT_POWER_CONTROL;
  // Unrecognised select codes leave both option pins undriven
  wire logic p3_on_66 = split_en[0] && (p3_sel_q == pss_pkg::P3_SEL_PIN_66);
  wire logic p3_on_5 = split_en[0] && (p3_sel_q == pss_pkg::P3_SEL_PIN_5);
  wire logic p4_on_6 = split_en[1] && (p4_sel_q == pss_pkg::P4_SEL_PIN_6);
  wire logic p4_on_4 = split_en[1] && (p4_sel_q == pss_pkg::P4_SEL_PIN_4);
  // Split pins are plain drivers; nothing here senses overcurrent on them
  assign O_GENERAL_PIN_66 = '{o: power_on[0], oe: p3_on_66};
  assign O_GENERAL_PIN_5 = '{o: power_on[0], oe: p3_on_5};
  assign O_GENERAL_PIN_6 = '{o: power_on[1], oe: p4_on_6};
  assign O_GENERAL_PIN_4 = '{o: power_on[1], oe: p4_on_4};

endmodule

// ===== pss_port_split_properties.sv
/*
  Checker for pss_port_split: register answers, pin routing, stuck link timing.
  Sees only the top ports; the bind follows the module.
*/
`timescale 1ns/1ps
module pss_port_split_properties #(
  parameter int TICK_CYC = 4
) (
  // Clock, reset and configuration
  input wire logic I_MCLK,
  input wire logic I_RESET_N,
  input wire pss_pkg::pss_cfg_req_s I_CFG_REQ,
  input wire logic [7:0] O_CFG_RDATA,
  input wire logic O_CFG_RVALID,
  input wire logic I_OTP_TIMEOUT_LOAD,
  input wire logic [2:0] I_OTP_TIMEOUT,
  // Port side
  input wire logic [3:0] I_PORT3_LINK_STATE,
  input wire logic [1:0] I_PORT_POWER_CONTROL,
  input wire logic [1:0] O_PORT_POWER_CONTROL_PIN,
  input wire pss_pkg::pss_pin_s O_GENERAL_PIN_66,
  input wire pss_pkg::pss_pin_s O_GENERAL_PIN_5,
  input wire pss_pkg::pss_pin_s O_GENERAL_PIN_6,
  input wire pss_pkg::pss_pin_s O_GENERAL_PIN_4
);
  // --------------------------------------------------------------------
  // Shadow registers and counters
  // --------------------------------------------------------------------
  wire pss_pkg::pss_cfg_req_s q = I_CFG_REQ;
  logic [7:0] en_q, s3_q, s4_q, pl_q;
  logic [3:0] ls_q;
  logic [2:0] tm_q;
  logic g_q, v_q;
  int st_q, lo_q, tmc, plc;
  function automatic int ms(input logic [2:0] c);
    case (c)
      3'h1: ms = 100;
      3'h2: ms = 250;
      3'h3: ms = 750;
      3'h4, 3'h5: ms = 1000;
      3'h6: ms = 2000;
      default: ms = 0;
    endcase
  endfunction
  assign tmc = ms(tm_q) * TICK_CYC;
  assign plc = (350 + 10 * int'(pl_q)) * TICK_CYC;
  wire sel66 = s3_q == 8'h42;
  wire e3 = g_q & en_q[5];
  wire e4 = g_q & en_q[6];
  // Counted only while pin 66 carries port 3, so a reselect never leaves a stale count
  wire stk = e3 && tmc != 0 && sel66 && O_GENERAL_PIN_66.o && ls_q == I_PORT3_LINK_STATE &&
    I_PORT3_LINK_STATE inside {[4'h4:4'h9]};
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      {en_q, s3_q, s4_q, g_q} <= '0;
      tm_q <= 3'h5;
      pl_q <= 8'h05;
      {ls_q, st_q, lo_q, v_q} <= '0;
    end else begin
      if (q.wr && q.addr == 16'h3c48) en_q <= q.wdata;
      if (q.wr && q.addr == 16'h4141) g_q <= q.wdata[0];
      if (q.wr && q.addr == 16'h416e) s3_q <= q.wdata;
      if (q.wr && q.addr == 16'h416f) s4_q <= q.wdata;
      if (q.wr && q.addr == 16'h4176) pl_q <= q.wdata;
      if (I_OTP_TIMEOUT_LOAD) tm_q <= I_OTP_TIMEOUT;
      else if (q.wr && q.addr == 16'h4171) tm_q <= q.wdata[2:0];
      ls_q <= I_PORT3_LINK_STATE;
      st_q <= stk ? st_q + 1 : 0;
      lo_q <= O_GENERAL_PIN_66.o ? 0 : lo_q + 1;
      v_q <= sel66 && (v_q || O_GENERAL_PIN_66.o);
    end
  end
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);
  sequence rd_take;
    q.rd;
  endsequence
  sequence rd_answer;
    O_CFG_RVALID;
  endsequence
  rd_answer_a: assert property (rd_take |=> rd_answer)
    else $error("read not answered next cycle");
  rvalid_cause_a: assert property (O_CFG_RVALID |-> $past(q.rd))
    else $error("read valid without a read");
  unmapped_zero_a: assert property (q.rd && !(q.addr inside {16'h3c48, 16'h4141, 16'h416e, 16'h416f,
    16'h4171, 16'h4176, 16'h4177}) |=> O_CFG_RDATA == 8'h00) else $error("unmapped read not zero");
  power_copy_a: assert property (O_PORT_POWER_CONTROL_PIN == I_PORT_POWER_CONTROL)
    else $error("port power pin differs from control");
  p3_route_a: assert property ({O_GENERAL_PIN_66.oe, O_GENERAL_PIN_5.oe} ==
    {e3 && sel66, e3 && s3_q == 8'h05}) else $error("port 3 split pin routing wrong");
  p4_route_a: assert property ({O_GENERAL_PIN_6.oe, O_GENERAL_PIN_4.oe} ==
    {e4 && s4_q == 8'h06, e4 && s4_q == 8'h04}) else $error("port 4 split pin routing wrong");
  toggle_cause_a: assert property ($fell(O_GENERAL_PIN_66.o) && sel66 |->
    $past(st_q) >= tmc - TICK_CYC) else $error("split pin toggled before timeout");
  stuck_bound_a: assert property (st_q <= tmc + TICK_CYC + 2)
    else $error("stuck link not toggled in time");
  pulse_len_a: assert property ($rose(O_GENERAL_PIN_66.o) && v_q |->
    lo_q >= plc - TICK_CYC && lo_q <= plc + TICK_CYC) else $error("low pulse length wrong");
endmodule

bind pss_port_split pss_port_split_properties #(.TICK_CYC(TICK_CYC)) u_chk (.I_MCLK, .I_RESET_N, .I_CFG_REQ,
  .O_CFG_RDATA, .O_CFG_RVALID, .I_OTP_TIMEOUT_LOAD, .I_OTP_TIMEOUT, .I_PORT3_LINK_STATE, .I_PORT_POWER_CONTROL,
  .O_PORT_POWER_CONTROL_PIN, .O_GENERAL_PIN_66, .O_GENERAL_PIN_5, .O_GENERAL_PIN_6, .O_GENERAL_PIN_4);

// ===== pss_embedded_dev.sv
/*
  Power switch and embedded device on one port's two split pin options.
  Assumes the switch enable has a pull-down: an undriven pin means power off.
*/
`timescale 1ns/1ps
module pss_embedded_dev #(
  parameter int TRAIN = 20
) (
  // Clock and fault control
  input wire logic i_clk,
  input wire logic i_hang,
  // Split pins
  input wire pss_pkg::pss_pin_s i_pin_a,
  input wire pss_pkg::pss_pin_s i_pin_b,
  // Training state seen by the hub
  output logic [3:0] o_link_state
);
  wire pwr = (i_pin_a.oe & i_pin_a.o) | (i_pin_b.oe & i_pin_b.o);
  int cnt = 0;
  always @(posedge i_clk) cnt <= pwr ? cnt + int'(cnt < TRAIN) : 0;
  // A hung device never leaves receiver detection, the stuck case to recover
  assign o_link_state = (!pwr || i_hang) ? 4'h5 : (cnt < TRAIN ? 4'h7 : 4'h0);
endmodule

// ===== tb_port_split_link_recovery.sv
/*
  Testbench for pss_port_split: register model, pin routing, stuck link recovery.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
module tb_port_split_link_recovery;
  localparam int TK = 4;
  logic clk = 1'b0, rst_n = 1'b0, otp_ld = 1'b0, h3 = 1'b0, h4 = 1'b0, rvalid;
  logic [2:0] otp_v = 3'h0;
  logic [1:0] ppc = 2'h0, ppc_pin;
  logic [7:0] rdata;
  logic [3:0] ls3, ls4;
  pss_pkg::pss_cfg_req_s req = '0;
  pss_pkg::pss_pin_s p66, p5, p6, p4;
  logic psel = 1'b0;
  // Pin that the waits watch: port 3 option A, or port 4 option B
  wire wo = psel ? p4.o : p66.o;
  logic [7:0] mdl [int], wm [int];
  int ad[6] = '{'h3c48, 'h4141, 'h416e, 'h416f, 'h4171, 'h4176};
  logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h05};
  logic [7:0] mk[6] = '{8'hfe, 8'h01, 8'hff, 8'hff, 8'h07, 8'hff};
  logic [7:0] c3[8] = '{8'h42, 8'h05, 8'h00, 8'h33, 8'h42, 8'h05, 8'h42, 8'h05};
  logic [7:0] c4[8] = '{8'h06, 8'h04, 8'h07, 8'h00, 8'h04, 8'h06, 8'h06, 8'h04};
  int tc[7] = '{1, 1, 2, 3, 4, 6, 5}, tms[7] = '{100, 100, 250, 750, 1000, 2000, 1000}, pc[7] = '{0, 5, 5, 5, 5, 5, 5};
  int n_mismatch = 0, cmp_count = 0;
  integer seed = 32'he5f7f5e6;
  always #25 clk = ~clk;
  pss_port_split #(.TICK_CYC(TK)) u_pss_port_split (.I_MCLK(clk), .I_RESET_N(rst_n), .I_CFG_REQ(req),
    .O_CFG_RDATA(rdata), .O_CFG_RVALID(rvalid), .I_OTP_TIMEOUT_LOAD(otp_ld), .I_OTP_TIMEOUT(otp_v),
    .I_PORT3_LINK_STATE(ls3), .I_PORT4_LINK_STATE(ls4), .I_PORT_POWER_CONTROL(ppc),
    .O_PORT_POWER_CONTROL_PIN(ppc_pin), .O_GENERAL_PIN_66(p66), .O_GENERAL_PIN_5(p5),
    .O_GENERAL_PIN_6(p6), .O_GENERAL_PIN_4(p4));
  pss_embedded_dev u_dev3 (.i_clk(clk), .i_hang(h3), .i_pin_a(p66), .i_pin_b(p5), .o_link_state(ls3));
  pss_embedded_dev u_dev4 (.i_clk(clk), .i_hang(h4), .i_pin_a(p6), .i_pin_b(p4), .o_link_state(ls4));
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic close_out();
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic near(input int n, input int e, input int tol);
    chk(16'((n - e <= tol && e - n <= tol) ? e : n), 16'(e));
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
    if (wm.exists(a)) mdl[a] = d & wm[a];
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge clk);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk);
    req.rd = 1'b0;
    chk({7'h0, rvalid, rdata}, {8'h01, mdl.exists(a) ? mdl[a] : 8'h00});
  endtask
  task automatic pins();
    logic e3, e4;
    e3 = mdl['h4141][0] & mdl['h3c48][5];
    e4 = mdl['h4141][0] & mdl['h3c48][6];
    ppc = 2'($random(seed));
    #1;
    chk({12'h0, p66.oe, p5.oe, p6.oe, p4.oe}, {12'h0, e3 && mdl['h416e] == 8'h42, e3 && mdl['h416e] == 8'h05,
      e4 && mdl['h416f] == 8'h06, e4 && mdl['h416f] == 8'h04});
    chk({14'h0, ppc_pin}, {14'h0, ppc});
  endtask
  task automatic wait_o(input logic lvl, input int lim, output int n);
    n = 0;
    while (wo !== lvl) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        chk({15'h0, wo}, {15'h0, lvl});
        close_out();
      end
    end
  endtask
  task automatic quiet(output int lo);
    lo = 0;
    repeat (1200) @(negedge clk) lo += int'(!wo);
  endtask
  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    int k, n;
    logic [15:0] a;
    foreach (ad[i]) begin
      wm[ad[i]] = mk[i];
      mdl[ad[i]] = rv[i];
    end
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    foreach (ad[i]) rd(16'(ad[i]));
    // Global enable kept off here so no recovery runs with a changing select
    repeat (40) begin
      k = int'($unsigned($random(seed)) % 7);
      a = k < 6 ? 16'(ad[k]) : 16'h4175;
      wr(a, 8'($random(seed)) & (a == 16'h4141 ? 8'hfe : 8'hff));
      rd(a);
    end
    otp_ld = 1'b1;
    otp_v = 3'h2;
    wr(16'h4171, 8'h03);
    otp_ld = 1'b0;
    mdl['h4171] = 8'h02;
    rd(16'h4171);
    for (int i = 0; i < 8; i++) begin
      wr(16'h416e, c3[i]);
      wr(16'h416f, c4[i]);
      wr(16'h3c48, 8'($random(seed)));
      wr(16'h4141, 8'($random(seed)));
      rd(16'h4141);
      pins();
    end
    wr(16'h3c48, 8'h00);
    h3 = 1'b1;
    wr(16'h4171, 8'h00);
    wr(16'h416e, 8'h42);
    wr(16'h4141, 8'h01);
    wr(16'h3c48, 8'h20);
    pins();
    quiet(n);
    chk(16'(n), 16'h0000);
    wr(16'h4171, 8'h07);
    quiet(n);
    chk(16'(n), 16'h0000);
    for (int i = 0; i < 7; i++) begin
      wr(16'h4171, 8'(tc[i]));
      wr(16'h4176, 8'(pc[i]));
      wait_o(1'b0, tms[i] * TK + 50, n);
      near(n + 3, tms[i] * TK, 2 * TK);
      wait_o(1'b1, 3000, n);
      near(n, (350 + 10 * pc[i]) * TK, TK);
    end
    h3 = 1'b0;
    // Short timeout so a healthy link wrongly taken as stuck would toggle in the window
    wr(16'h4171, 8'h01);
    quiet(n);
    chk(16'(n), 16'h0000);
    // Port 4 through its option B pin, with port 3 switched off
    psel = 1'b1;
    h4 = 1'b1;
    wr(16'h416f, 8'h04);
    wr(16'h4176, 8'h00);
    wr(16'h3c48, 8'h40);
    pins();
    wait_o(1'b0, 100 * TK + 50, n);
    near(n, 100 * TK, 2 * TK);
    mdl['h4177] = 8'h0a;
    rd(16'h4177);
    wait_o(1'b1, 3000, n);
    near(n + 2, 350 * TK, TK);
    close_out();
  end
endmodule
